// >>> ddrc_pkg.sv
package ddrc_pkg;
  // ==========================================================
  // Serial frame layout
  localparam int FRAME_BITS = 16;
  localparam int CODE_W     = 12;
  localparam int CNT_W      = 5;

  // ==========================================================
  // Power mode codes
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_PD_1K   = 2'h1;
  localparam logic [1:0] MODE_PD_100K = 2'h2;
  localparam logic [1:0] MODE_PD_HIZ  = 2'h3;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_DAC_A  = 8'h04;
  localparam logic [7:0] ADDR_DAC_B  = 8'h08;
  localparam logic [7:0] ADDR_IN_A   = 8'h0C;
  localparam logic [7:0] ADDR_IN_B   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam int CTRL_SOFT_LOAD  = 0;
  localparam int CTRL_SOFT_CLEAR = 1;

  // ==========================================================
  // Bus constants
  localparam logic       HRESP_OKAY = 1'h0;
  localparam logic [1:0] HTRANS_NSQ = 2'h2;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic              span;
    logic              modeBitHi;
    logic              modeBitLo;
    logic [CODE_W-1:0] code;
  } ddrc_chan_s;

  typedef struct packed {
    logic       chanB;
    ddrc_chan_s body;
  } ddrc_frame_s;

  typedef struct packed {
    logic [7:0] spare;
    logic [7:0] aborts;
    logic [7:0] frames;
    logic [3:0] spare2;
    logic       clearLevel;
    logic       loadLevel;
    logic       pendingB;
    logic       pendingA;
  } ddrc_status_s;

  localparam ddrc_chan_s CHAN_RESET = '0;
endpackage

// >>> ddrc_serial_rx.sv
`timescale 1ns/1ps
module ddrc_serial_rx (
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  input  wire logic                     sclkPin,
  input  wire logic                     frameSel_n,
  input  wire logic                     serialDin,
  output      ddrc_pkg::ddrc_frame_s    frameWord,
  output      logic                     frameDone,
  output      logic                     frameAbort
);
  import ddrc_pkg::*;

  logic [2:0]            sclkSync_reg;
  logic [2:0]            selSync_reg;
  logic [1:0]            dinSync_reg;
  logic [CNT_W-1:0]      bitCnt_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic                  done_reg;
  logic                  abort_reg;
  logic                  selected;
  logic                  sclkFall;
  logic                  selRise;
  logic                  shiftEn;

  // ==========================================================
  // Pin synchronisers, stage 0 feeds only stage 1
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sclkSync_reg <= 3'h0;
      selSync_reg  <= 3'h7;
      dinSync_reg  <= 2'h0;
    end else begin
      sclkSync_reg <= {sclkSync_reg[1:0], sclkPin};
      selSync_reg  <= {selSync_reg[1:0], frameSel_n};
      dinSync_reg  <= {dinSync_reg[0], serialDin};
    end
  end

  // Edge detection; host clock half period must span two ref cycles
  assign selected = ~selSync_reg[1];
  assign sclkFall = sclkSync_reg[2] & ~sclkSync_reg[1];
  assign selRise  = selSync_reg[1] & ~selSync_reg[2];
  assign shiftEn  = selected & sclkFall & (bitCnt_reg < CNT_W'(FRAME_BITS));

  // Shift on falling edges, stop after the last bit
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bitCnt_reg <= '0;
      shift_reg  <= '0;
      done_reg   <= 1'b0;
      abort_reg  <= 1'b0;
    end else begin
      done_reg  <= shiftEn & (bitCnt_reg == CNT_W'(FRAME_BITS - 1));
      abort_reg <= selRise & (bitCnt_reg != '0) & (bitCnt_reg < CNT_W'(FRAME_BITS));
      if (!selected) begin
        bitCnt_reg <= '0;
      end else if (shiftEn) begin
        bitCnt_reg <= bitCnt_reg + 1'b1;
      end
      if (shiftEn) begin
        shift_reg <= {shift_reg[FRAME_BITS-2:0], dinSync_reg[1]};
      end
    end
  end

  assign frameWord  = ddrc_frame_s'(shift_reg);
  assign frameDone  = done_reg;
  assign frameAbort = abort_reg;

  chk_done_count : assert property (@(posedge ref_clk) disable iff (!resetn)
    done_reg |-> bitCnt_reg == CNT_W'(FRAME_BITS))
    else $error("frame accepted at wrong bit count");
  chk_idle_ignore : assert property (@(posedge ref_clk) disable iff (!resetn)
    !selected |=> $stable(shift_reg) && bitCnt_reg == '0)
    else $error("shift register moved while deselected");
  chk_abort_nodone : assert property (@(posedge ref_clk) disable iff (!resetn)
    abort_reg |-> !done_reg ##1 !done_reg)
    else $error("aborted frame was accepted");
endmodule

// >>> ddrc_channel.sv
`timescale 1ns/1ps
module ddrc_channel (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic                 clear,
  input  wire logic                 wrEn,
  input       ddrc_pkg::ddrc_chan_s wrData,
  input  wire logic                 loadLow,
  input  wire logic                 loadFall,
  output      ddrc_pkg::ddrc_chan_s inputWord,
  output      ddrc_pkg::ddrc_chan_s dacWord,
  output      logic                 pending,
  output      logic                 ampOn
);
  import ddrc_pkg::*;

  ddrc_chan_s input_reg;
  ddrc_chan_s dac_reg;
  logic       pending_reg;
  logic       ampOn_reg;
  logic       passThru;
  logic       transfer;

  // ==========================================================
  // Transfer decisions
  assign passThru = wrEn & loadLow;
  assign transfer = loadFall & pending_reg;

  // Input and DAC registers, clear overrides everything
  always_ff @(posedge ref_clk) begin
    if (!resetn || clear) begin
      input_reg   <= CHAN_RESET;
      dac_reg     <= CHAN_RESET;
      pending_reg <= 1'b0;
    end else begin
      if (wrEn) begin
        input_reg <= wrData;
      end
      if (passThru) begin
        dac_reg <= wrData;
      end else if (transfer) begin
        dac_reg <= input_reg;
      end
      pending_reg <= (wrEn & ~loadLow) | (pending_reg & ~transfer);
    end
  end

  // Amplifier runs only in normal mode
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ampOn_reg <= 1'b1;
    end else begin
      ampOn_reg <= {dac_reg.modeBitHi, dac_reg.modeBitLo} == MODE_NORMAL;
    end
  end

  assign inputWord = input_reg;
  assign dacWord   = dac_reg;
  assign pending   = pending_reg;
  assign ampOn     = ampOn_reg;

  chk_hold_latched : assert property (@(posedge ref_clk) disable iff (!resetn)
    !loadLow && !loadFall && !clear |=> $stable(dac_reg))
    else $error("DAC register changed while latched");
  chk_pass_thru : assert property (@(posedge ref_clk) disable iff (!resetn)
    passThru && !clear |=> dac_reg == $past(wrData))
    else $error("write did not pass through");
  chk_clear_zero : assert property (@(posedge ref_clk) disable iff (!resetn)
    clear |=> dac_reg == CHAN_RESET && input_reg == CHAN_RESET && !pending_reg)
    else $error("clear left nonzero state");
  chk_stale_skip : assert property (@(posedge ref_clk) disable iff (!resetn)
    loadFall && !pending_reg && !wrEn && !clear |=> $stable(dac_reg))
    else $error("load updated a stale register");
  chk_amp_mode : assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(resetn) |-> ampOn_reg ==
      ({$past(dac_reg.modeBitHi), $past(dac_reg.modeBitLo)} == MODE_NORMAL))
    else $error("amplifier state does not follow mode");
endmodule

// >>> ddrc_top.sv
`timescale 1ns/1ps
module ddrc_top #(
  parameter int DATA_W = 12
) (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output      logic                    hreadyout,
  output      logic [31:0]             hrdata,
  output      logic                    hresp,
  input  wire logic                    sclkPin,
  input  wire logic                    frameSel_n,
  input  wire logic                    serialDin,
  input  wire logic                    zero_all_n,
  input  wire logic                    dac_load_n,
  input  wire logic                    refBufPinA,
  input  wire logic                    refBufPinB,
  output      logic [DATA_W-1:0]       tapCodeA,
  output      logic [DATA_W-1:0]       tapCodeB,
  output      logic                    spanDoubleA,
  output      logic                    spanDoubleB,
  output      logic [1:0]              modeA,
  output      logic [1:0]              modeB,
  output      logic                    ampOnA,
  output      logic                    ampOnB,
  output      logic                    refBufEnA,
  output      logic                    refBufEnB
);
  import ddrc_pkg::*;

  // ==========================================================
  // Elaboration check
  if (DATA_W != 8 && DATA_W != 10 && DATA_W != 12) begin : g_badWidth
    $error("DATA_W must be 8, 10 or 12");
  end

  localparam logic [CODE_W-1:0] CODE_MASK = ~CODE_W'((1 << (CODE_W - DATA_W)) - 1);

  // Word view of a channel register
  function automatic logic [31:0] chanWord(input ddrc_chan_s c);
    chanWord = 32'(c);
  endfunction

  // ==========================================================
  // Control pin synchronisers
  logic [3:0] pinSync1_reg;
  logic [3:0] pinSync2_reg;
  logic       loadPrev_reg;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pinSync1_reg <= 4'h3;
      pinSync2_reg <= 4'h3;
      loadPrev_reg <= 1'b1;
    end else begin
      pinSync1_reg <= {refBufPinB, refBufPinA, dac_load_n, zero_all_n};
      pinSync2_reg <= pinSync1_reg;
      loadPrev_reg <= pinSync2_reg[1];
    end
  end

  // ==========================================================
  // Serial receiver
  ddrc_frame_s frameWord;
  logic        frameDone;
  logic        frameAbort;

  ddrc_serial_rx u_rx (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .sclkPin    (sclkPin),
    .frameSel_n (frameSel_n),
    .serialDin  (serialDin),
    .frameWord  (frameWord),
    .frameDone  (frameDone),
    .frameAbort (frameAbort)
  );

  // ==========================================================
  // Bus slave state
  logic       wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic [31:0] hrdata_reg;
  logic       hreadyout_reg;
  logic       hresp_reg;
  logic       softLoad_reg;
  logic       softClear_reg;
  logic [7:0] frameCnt_reg;
  logic [7:0] abortCnt_reg;

  // Channel strobes and data
  ddrc_chan_s wrWord;
  ddrc_chan_s inA;
  ddrc_chan_s inB;
  ddrc_chan_s dacA;
  ddrc_chan_s dacB;
  ddrc_status_s status;
  logic       clear;
  logic       loadLow;
  logic       loadFall;
  logic       wrA;
  logic       wrB;
  logic       pendA;
  logic       pendB;
  logic       addrPhase;
  logic       ctrlWrite;
  logic [31:0] readData;

  // Strobes from pins, soft control and frames
  assign clear    = ~pinSync2_reg[0] | softClear_reg;
  assign loadLow  = ~pinSync2_reg[1];
  assign loadFall = (loadPrev_reg & ~pinSync2_reg[1]) | softLoad_reg;
  assign wrA      = frameDone & ~frameWord.chanB;
  assign wrB      = frameDone & frameWord.chanB;
  assign wrWord   = '{span:      frameWord.body.span,
                      modeBitHi: frameWord.body.modeBitHi,
                      modeBitLo: frameWord.body.modeBitLo,
                      code:      frameWord.body.code & CODE_MASK};

  ddrc_channel u_chanA (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clear     (clear),
    .wrEn      (wrA),
    .wrData    (wrWord),
    .loadLow   (loadLow),
    .loadFall  (loadFall),
    .inputWord (inA),
    .dacWord   (dacA),
    .pending   (pendA),
    .ampOn     (ampOnA)
  );

  ddrc_channel u_chanB (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clear     (clear),
    .wrEn      (wrB),
    .wrData    (wrWord),
    .loadLow   (loadLow),
    .loadFall  (loadFall),
    .inputWord (inB),
    .dacWord   (dacB),
    .pending   (pendB),
    .ampOn     (ampOnB)
  );

  // ==========================================================
  // Bus decode and read selection
  assign addrPhase = hsel & hready & (htrans == HTRANS_NSQ);
  assign ctrlWrite = wrPend_reg & (wrAddr_reg == ADDR_CTRL);
  assign status    = '{spare: 8'h00, aborts: abortCnt_reg, frames: frameCnt_reg,
                       spare2: 4'h0, clearLevel: pinSync2_reg[0],
                       loadLevel: pinSync2_reg[1], pendingB: pendB, pendingA: pendA};
  assign readData  = (haddr[7:0] == ADDR_DAC_A)  ? chanWord(dacA) :
                     (haddr[7:0] == ADDR_DAC_B)  ? chanWord(dacB) :
                     (haddr[7:0] == ADDR_IN_A)   ? chanWord(inA) :
                     (haddr[7:0] == ADDR_IN_B)   ? chanWord(inB) :
                     (haddr[7:0] == ADDR_STATUS) ? 32'(status) : 32'h0000_0000;

  // Address phase capture, read data ready for the data phase
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wrPend_reg    <= 1'b0;
      wrAddr_reg    <= 8'h00;
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= HRESP_OKAY;
    end else begin
      wrPend_reg    <= addrPhase & hwrite;
      wrAddr_reg    <= haddr[7:0];
      hreadyout_reg <= 1'b1;
      hresp_reg     <= HRESP_OKAY;
      if (addrPhase && !hwrite) begin
        hrdata_reg <= readData;
      end
    end
  end

  // Soft control pulses, one cycle each
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      softLoad_reg  <= 1'b0;
      softClear_reg <= 1'b0;
    end else begin
      softLoad_reg  <= ctrlWrite & hwdata[CTRL_SOFT_LOAD];
      softClear_reg <= ctrlWrite & hwdata[CTRL_SOFT_CLEAR];
    end
  end

  // Frame and abort counters, wrap at 255
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      frameCnt_reg <= 8'h00;
      abortCnt_reg <= 8'h00;
    end else begin
      frameCnt_reg <= frameCnt_reg + 8'(frameDone);
      abortCnt_reg <= abortCnt_reg + 8'(frameAbort);
    end
  end

  // Reference buffer enables follow the synchronised pins
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      refBufEnA <= 1'b0;
      refBufEnB <= 1'b0;
    end else begin
      refBufEnA <= pinSync2_reg[2];
      refBufEnB <= pinSync2_reg[3];
    end
  end

  // ==========================================================
  // Outputs from the DAC registers and the bus slave registers
  assign tapCodeA    = dacA.code[CODE_W-1 -: DATA_W];
  assign tapCodeB    = dacB.code[CODE_W-1 -: DATA_W];
  assign spanDoubleA = dacA.span;
  assign spanDoubleB = dacB.span;
  assign modeA       = {dacA.modeBitHi, dacA.modeBitLo};
  assign modeB       = {dacB.modeBitHi, dacB.modeBitLo};
  assign hreadyout   = hreadyout_reg;
  assign hrdata      = hrdata_reg;
  assign hresp       = hresp_reg;

  // ==========================================================
  // Checks
  sequence frameToA;
    wrA && !clear;
  endsequence

  sequence frameToB;
    wrB && !clear;
  endsequence

  chk_reset_zero : assert property (@(posedge ref_clk)
    $rose(resetn) |-> dacA == CHAN_RESET && dacB == CHAN_RESET && inA == CHAN_RESET)
    else $error("registers not zero after reset");
  chk_reset_span : assert property (@(posedge ref_clk)
    $rose(resetn) |-> !spanDoubleA && !spanDoubleB && tapCodeA == '0 && modeA == MODE_NORMAL)
    else $error("wrong range after reset");
  chk_buf_select : assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(resetn, 3) |-> refBufEnA == $past(refBufPinA, 3) && refBufEnB == $past(refBufPinB, 3))
    else $error("buffer enable does not follow pin");
  chk_route_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    frameToA |=> inA == $past(wrWord) && $stable(inB))
    else $error("frame for A misrouted");
  chk_route_b : assert property (@(posedge ref_clk) disable iff (!resetn)
    frameToB |=> inB == $past(wrWord) && $stable(inA))
    else $error("frame for B misrouted");

  // Clear pin low through both synchroniser stages
  sequence clearSeen;
    !pinSync1_reg[0] ##1 !pinSync2_reg[0];
  endsequence

  // Frame for A while the load strobe is high
  sequence latchedToA;
    wrA && !clear && !loadLow;
  endsequence

  // Frame for B while the load strobe is high
  sequence latchedToB;
    wrB && !clear && !loadLow;
  endsequence

  chk_clear_pin : assert property (@(posedge ref_clk) disable iff (!resetn)
    clearSeen |=> dacA == CHAN_RESET && dacB == CHAN_RESET && inB == CHAN_RESET)
    else $error("clear pin left nonzero state");
  chk_soft_clear : assert property (@(posedge ref_clk) disable iff (!resetn)
    ctrlWrite && hwdata[CTRL_SOFT_CLEAR] |-> ##2 inA == CHAN_RESET && inB == CHAN_RESET)
    else $error("soft clear left nonzero state");
  chk_pend_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    latchedToA |=> pendA)
    else $error("latched write to A not pending");
  chk_pend_b : assert property (@(posedge ref_clk) disable iff (!resetn)
    latchedToB |=> pendB)
    else $error("latched write to B not pending");
  chk_frame_count : assert property (@(posedge ref_clk) disable iff (!resetn)
    frameDone |=> frameCnt_reg == $past(frameCnt_reg) + 8'h01)
    else $error("accepted frame not counted");
  chk_abort_count : assert property (@(posedge ref_clk) disable iff (!resetn)
    frameAbort |=> abortCnt_reg == $past(abortCnt_reg) + 8'h01)
    else $error("aborted frame not counted");
  chk_bus_okay : assert property (@(posedge ref_clk) disable iff (!resetn)
    hreadyout && hresp == HRESP_OKAY)
    else $error("bus answer not ready and okay");
endmodule

// >>> ddrc_host_model.sv
`timescale 1ns/1ps
module ddrc_host_model (
  output logic sclkPin,
  output logic frameSel_n,
  output logic serialDin
);
  localparam int HALF = 32;

  // ==========================================================
  // Idle lines: clock parked high, frame deselected
  initial begin
    sclkPin    = 1'b1;
    frameSel_n = 1'b1;
    serialDin  = 1'b1;
  end

  // ==========================================================
  // One frame, cut short when nBits is below sixteen
  task automatic send(input logic [15:0] word, input int nBits);
    frameSel_n = 1'b0;
    #HALF;
    for (int i = 15; i > 15 - nBits; i--) begin
      sclkPin   = 1'b1;
      serialDin = word[i];
      #HALF;
      sclkPin = 1'b0;
      #HALF;
    end
    sclkPin = 1'b1;
    #HALF;
    frameSel_n = 1'b1;
    serialDin  = ~serialDin; // Released line shows no stale bit
    #(4 * HALF);
  endtask

  // Clock and data toggling while the frame stays deselected
  task automatic noise(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      sclkPin   = ~sclkPin;
      serialDin = ~serialDin;
      #HALF;
    end
  endtask
endmodule

// >>> ddrc_top_tb.sv
`timescale 1ns/1ps
module ddrc_top_tb;
  import ddrc_pkg::*;

  // ==========================================================
  // Signals
  logic        ref_clk = 1'b0;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        sclkPin;
  logic        frameSel_n;
  logic        serialDin;
  logic        zero_all_n;
  logic        dac_load_n;
  logic        refBufPinA;
  logic        refBufPinB;
  logic [11:0] tapCodeA;
  logic [11:0] tapCodeB;
  logic        spanDoubleA;
  logic        spanDoubleB;
  logic [1:0]  modeA;
  logic [1:0]  modeB;
  logic        ampOnA;
  logic        ampOnB;
  logic        refBufEnA;
  logic        refBufEnB;
  logic [31:0] rd;
  int          n_errors = 0;
  int          checks = 0;

  // Clock generator
  always #2.5 ref_clk = ~ref_clk;

  // ==========================================================
  // Design and host
  ddrc_top #(.DATA_W(12)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sclkPin(sclkPin),
    .frameSel_n(frameSel_n), .serialDin(serialDin), .zero_all_n(zero_all_n),
    .dac_load_n(dac_load_n), .refBufPinA(refBufPinA), .refBufPinB(refBufPinB),
    .tapCodeA(tapCodeA), .tapCodeB(tapCodeB), .spanDoubleA(spanDoubleA),
    .spanDoubleB(spanDoubleB), .modeA(modeA), .modeB(modeB), .ampOnA(ampOnA),
    .ampOnB(ampOnB), .refBufEnA(refBufEnA), .refBufEnB(refBufEnB)
  );

  ddrc_host_model host (.sclkPin(sclkPin), .frameSel_n(frameSel_n), .serialDin(serialDin));

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wait_ready();
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask

  // Single word transfer; entered just after a rising edge
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= HTRANS_NSQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask

  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  task automatic frame(input logic [15:0] w, input int n);
    host.send(w, n);
    @(posedge ref_clk);
    cyc(8);
  endtask

  task automatic load_pulse();
    dac_load_n <= 1'b0;
    cyc(2);
    dac_load_n <= 1'b1;
    cyc(6);
  endtask

  task automatic conclude();
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog
  initial begin
    #100_000;
    n_errors++;
    conclude();
  end

  // ==========================================================
  // Test sequence
  initial begin
    resetn     = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0000_0000;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hwdata     = 32'h0000_0000;
    zero_all_n = 1'b1;
    dac_load_n = 1'b1;
    refBufPinA = 1'b0;
    refBufPinB = 1'b0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(4);
    check("outs", {tapCodeA, tapCodeB, spanDoubleA, spanDoubleB, modeA, modeB, ampOnA, ampOnB},
          32'h0000_0003);
    for (int a = 1; a <= 4; a++) rd_check("regs", 8'(4 * a), 32'h0000_0000);
    // Load high: code waits in the input register
    frame(16'h4ABC, 16);
    rd_check("inA", ADDR_IN_A, 32'h0000_4ABC);
    check("tapA held", {20'h0_0000, tapCodeA}, 32'h0000_0000);
    rd_check("status", ADDR_STATUS, 32'h0000_010D);
    // Aborted frame, then deselected toggling
    frame(16'h8FFF, 10);
    host.noise(20);
    cyc(8);
    rd_check("inB", ADDR_IN_B, 32'h0000_0000);
    rd_check("aborts", ADDR_STATUS, 32'h0001_010D);
    // Low pulse moves only the pending channel
    load_pulse();
    check("loadA", {tapCodeA, spanDoubleA, tapCodeB}, {12'hABC, 1'b1, 12'h000});
    rd_check("dacA", ADDR_DAC_A, 32'h0000_4ABC);
    rd_check("pend", ADDR_STATUS, 32'h0001_010C);
    // Load held low: every mode, codes pass straight through
    dac_load_n <= 1'b0;
    cyc(4);
    for (int m = 0; m < 4; m++) begin
      frame({1'b1, m[0], 2'(3 - m), 12'(m * 1365)}, 16);
      check("chB", {tapCodeB, spanDoubleB, modeB, ampOnB, tapCodeA},
            {12'(m * 1365), m[0], 2'(3 - m), 1'(m == 3), 12'hABC});
    end
    dac_load_n <= 1'b1;
    // Reference buffer pins
    for (int p = 0; p < 4; p++) begin
      refBufPinA <= p[0];
      refBufPinB <= p[1];
      cyc(5);
      check("refbuf", {30'h0, refBufEnB, refBufEnA}, {30'h0, p[1], p[0]});
    end
    // Unmapped and control reads
    bus(8'h20, 1'b1, 32'hFFFF_FFFF);
    rd_check("unmapped", 8'h20, 32'h0000_0000);
    rd_check("ctrl", ADDR_CTRL, 32'h0000_0000);
    // Soft load through the control word
    frame(16'h3321, 16);
    bus(ADDR_CTRL, 1'b1, 32'h0000_0001);
    cyc(4);
    check("softload", {20'h0_0000, tapCodeA}, 32'h0000_0321);
    check("modes", {26'h000_0000, modeA, ampOnA, modeB, ampOnB},
          {26'h000_0000, 2'h3, 1'b0, 2'h0, 1'b1});
    // Clear held across a full frame
    zero_all_n <= 1'b0;
    cyc(1);
    frame(16'h4777, 16);
    zero_all_n <= 1'b1;
    cyc(6);
    check("clear", {tapCodeA, tapCodeB, spanDoubleA, spanDoubleB, modeA, modeB},
          32'h0000_0000);
    rd_check("clrA", ADDR_IN_A, 32'h0000_0000);
    rd_check("clrB", ADDR_IN_B, 32'h0000_0000);
    // Soft clear drops a pending code
    frame(16'h2555, 16);
    rd_check("inA2", ADDR_IN_A, 32'h0000_2555);
    bus(ADDR_CTRL, 1'b1, 32'h0000_0002);
    cyc(4);
    rd_check("sclrA", ADDR_IN_A, 32'h0000_0000);
    rd_check("sclrSt", ADDR_STATUS, 32'h0001_080C);
    conclude();
  end
endmodule
